/* File: hdl/rtsc_ctrl.sv */
// Functional notes
// - Output off, fast select high: key held low 2.3 s turns output on.
// - Fast select low before key falls while off: output on within 4 ms.
// - Output on, key held low reset hold delay: 400 ms off then on.
// - Fast select low before key falls while on: off within 1 ms.
// - Test mode keeps reset off pulse at 400 ms.
// - Simultaneous triggers: key first, wake second, shutdown third; rest ignored.
// - Key or wake trigger aborts long shutdown countdown, output stays on.
// - Trim code scales reset hold delay from half to double.
// - Trim tied to battery gives unscaled reset hold delay.
// - Trim resistor connected only briefly after key falls.
// - After reset inputs assumed idle and output on.
// - Wake high with key high turns output on after 4.4 ms.
// - Shutdown rising edge held 1 ms starts turn-off, long or short delay.
// - After turning on, no reset until key returns high.
// - Key released before reset hold delay clears counter, output stays on.
`timescale 1ns/10ps
module rtsc_ctrl
  import rtsc_pkg::*;
#(
  parameter logic [CNT_W-1:0] TURN_ON_CYC = CNT_W'(rtsc_min_cyc(TURN_ON_DELAY_US)),
  parameter logic [CNT_W-1:0] RESET_HOLD_CYC = CNT_W'(rtsc_min_cyc(RESET_HOLD_DELAY_US)),
  parameter logic [CNT_W-1:0] RESET_OFF_CYC = CNT_W'(rtsc_min_cyc(RESET_OFF_PULSE_US)),
  parameter logic [CNT_W-1:0] SHUTDOWN_CYC = CNT_W'(rtsc_min_cyc(SHUTDOWN_DELAY_US))
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic power_key_n_in,
  input wire logic wake_request_in,
  input wire logic shutdown_request_in,
  input wire logic fast_select_n_in,
  input wire logic [2:0] delay_trim_pin_in,
  output logic delay_trim_pin_enable_out,
  output logic switch_on_out
);
  typedef enum logic [2:0] {
    ST_ON, ST_OFF, ST_WAKE_WAIT, ST_ARMED_WAIT, ST_RESET_OFF, ST_SHUT_HOLD, ST_SHUT_WAIT
  } rtsc_state_t;

  rtsc_state_t state;
  rtsc_in_t raw;
  rtsc_in_t cur;
  rtsc_in_t prev;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] trim_count;
  logic [CNT_W-1:0] reset_limit;
  logic [CNT_W-1:0] shut_limit;
  logic reset_armed;
  logic fast_at_fall;
  logic key_fall;
  logic key_low;
  logic wake_rise;
  logic off_rise;
  logic take_key;
  logic take_wake;
  logic take_off;
  logic [2:0] trim_code;

  assign raw = '{key_n: power_key_n_in, wake: wake_request_in,
                 off: shutdown_request_in, fast_n: fast_select_n_in};

  rtsc_sync u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .raw_in(raw),
    .sync_out(cur),
    .prev_out(prev)
  );

  // Edges on synchronised levels
  assign key_fall = prev.key_n && !cur.key_n;
  assign key_low = !cur.key_n;
  assign wake_rise = !prev.wake && cur.wake;
  assign off_rise = !prev.off && cur.off;

  // Fixed priority: key, then wake, then shutdown
  assign take_key = key_fall;
  assign take_wake = wake_rise && !key_fall;
  assign take_off = off_rise && !key_fall && !wake_rise;

  // Scale hold delay by quarters of the factory value
  function automatic logic [CNT_W-1:0] rtsc_scale(input logic [CNT_W-1:0] base,
                                                  input logic [2:0] code);
    logic [3:0] qtr;
    logic [CNT_W+3:0] prod;
    qtr = QTR_ONE;
    case (rtsc_trim_t'(code))
      TRIM_GND: qtr = 4'h2;
      TRIM_3K9: qtr = 4'h3;
      TRIM_10K: qtr = 4'h5;
      TRIM_22K: qtr = 4'h6;
      TRIM_47K: qtr = 4'h7;
      TRIM_120K: qtr = 4'h8;
      default: qtr = QTR_ONE;
    endcase
    prod = (CNT_W+4)'(base) * (CNT_W+4)'(qtr);
    return prod[CNT_W+1:2];
  endfunction : rtsc_scale

  // Trim pin connected for a short window after each key fall
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      trim_count <= '0;
      trim_code <= 3'(TRIM_VBAT);
    end else if (key_fall) begin
      trim_count <= TRIM_WINDOW_CYC;
    end else if (trim_count != '0) begin
      trim_count <= trim_count - 1'b1;
      trim_code <= delay_trim_pin_in;
    end
  end
  assign delay_trim_pin_enable_out = (trim_count != '0);

  always_comb begin
    reset_limit = rtsc_scale(RESET_HOLD_CYC, trim_code);
    if (fast_at_fall) begin
      reset_limit = FAST_RESET_CYC;
    end
    shut_limit = cur.fast_n ? SHUTDOWN_CYC : FAST_SHUTDOWN_CYC;
  end

  // Fast select level sampled before the key falls
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      fast_at_fall <= 1'b0;
    end else if (key_fall) begin
      fast_at_fall <= !prev.fast_n;
    end
  end

  // Reset re-enabled only once key returns high
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      reset_armed <= 1'b1;
    end else if (state != ST_ON && state != ST_SHUT_HOLD && state != ST_SHUT_WAIT) begin
      reset_armed <= 1'b0;
    end else if (cur.key_n) begin
      reset_armed <= 1'b1;
    end
  end

  // Single timebase counter and sequencer
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state <= ST_ON;
      count <= '0;
    end else begin
      case (state)
        ST_ON: begin
          count <= '0;
          if (take_key && reset_armed) begin
            state <= ST_ARMED_WAIT;
          end else if (take_off) begin
            state <= ST_SHUT_HOLD;
          end
        end
        ST_ARMED_WAIT: begin
          if (!key_low) begin
            state <= ST_ON;
            count <= '0;
          end else if (count + 1'b1 >= reset_limit) begin
            state <= ST_RESET_OFF;
            count <= '0;
          end else begin
            count <= count + 1'b1;
          end
        end
        ST_RESET_OFF: begin
          if (count + 1'b1 >= RESET_OFF_CYC) begin
            state <= ST_ON;
            count <= '0;
          end else begin
            count <= count + 1'b1;
          end
        end
        ST_SHUT_HOLD: begin
          if (take_key || take_wake) begin
            state <= ST_ON;
          end else if (!cur.off) begin
            state <= ST_ON;
            count <= '0;
          end else if (count + 1'b1 >= OFF_HOLD_CYC) begin
            state <= ST_SHUT_WAIT;
            count <= '0;
          end else begin
            count <= count + 1'b1;
          end
        end
        ST_SHUT_WAIT: begin
          if (cur.fast_n && (take_key || take_wake)) begin
            state <= ST_ON;
            count <= '0;
          end else if (count + 1'b1 >= shut_limit) begin
            state <= ST_OFF;
            count <= '0;
          end else begin
            count <= count + 1'b1;
          end
        end
        ST_OFF: begin
          count <= '0;
          if (key_low) begin
            state <= ST_WAKE_WAIT;
          end else if (take_wake || cur.wake) begin
            state <= ST_WAKE_WAIT;
          end
        end
        ST_WAKE_WAIT: begin
          if (take_key) begin
            count <= '0;
          end else if (key_low) begin
            if (count + 1'b1 >= (fast_at_fall ? FAST_ON_CYC : TURN_ON_CYC)) begin
              state <= ST_ON;
              count <= '0;
            end else begin
              count <= count + 1'b1;
            end
          end else if (cur.wake) begin
            if (count + 1'b1 >= WAKE_ON_CYC) begin
              state <= ST_ON;
              count <= '0;
            end else begin
              count <= count + 1'b1;
            end
          end else begin
            state <= ST_OFF;
            count <= '0;
          end
        end
        default: begin
          state <= ST_ON;
          count <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      switch_on_out <= 1'b1;
    end else begin
      switch_on_out <= (state != ST_OFF && state != ST_WAKE_WAIT && state != ST_RESET_OFF);
    end
  end

  AST_PRIO_KEY: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state == ST_ON && key_fall && reset_armed && off_rise) |=> state == ST_ARMED_WAIT)
    else $error("Key lost priority to shutdown");
  AST_RELEASE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state == ST_ARMED_WAIT && cur.key_n) |=> state == ST_ON)
    else $error("Released key did not clear reset count");
  AST_ABORT: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state == ST_SHUT_WAIT && cur.fast_n && (take_key || take_wake)) |=> state == ST_ON)
    else $error("Wake did not abort turn-off");
  sequence s_pulse_start;
    state == ST_RESET_OFF && $past(state) == ST_ARMED_WAIT;
  endsequence
  AST_PULSE_OFF: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    s_pulse_start |=> !switch_on_out)
    else $error("Switch not off during reset pulse");
  AST_TRIM_WIN: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    key_fall |=> delay_trim_pin_enable_out)
    else $error("Trim not connected after key fall");
  AST_TRIM_IDLE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (trim_count == '0 && !key_fall) |=> !delay_trim_pin_enable_out)
    else $error("Trim connected outside window");
  AST_NO_REARM: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state == ST_ON && !reset_armed && key_low) |=> state != ST_ARMED_WAIT)
    else $error("Reset started before key release");
  AST_WAKE_ON: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state == ST_OFF && cur.wake && cur.key_n) |=> state == ST_WAKE_WAIT)
    else $error("Wake did not start turn-on");
  AST_POR_ON: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $fell(rst_in) |-> switch_on_out)
    else $error("Switch not on after reset");
  AST_OFF_STAYS: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state == ST_OFF && cur.key_n && !cur.wake) |=> state == ST_OFF)
    else $error("Switch left off state without request");
  sequence s_turn_on;
    state == ST_WAKE_WAIT ##1 state == ST_ON;
  endsequence
  AST_DISARM_ON: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    s_turn_on |-> !reset_armed)
    else $error("Reset armed right after turn-on");
  AST_REARM: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state == ST_ON && cur.key_n) |=> reset_armed)
    else $error("Reset not armed after key release");
  sequence s_release;
    state == ST_ARMED_WAIT ##1 state == ST_ON;
  endsequence
  AST_RELEASE_ON: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    s_release |=> switch_on_out)
    else $error("Switch dropped after early key release");
  AST_PRIO_OFF_DROP: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state == ST_ON && key_fall && off_rise) |=> state != ST_SHUT_HOLD)
    else $error("Shutdown served over key");
  AST_OFF_LEVEL: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state == ST_ON && cur.off && !off_rise) |=> state != ST_SHUT_HOLD)
    else $error("Shutdown level without edge started turn-off");
endmodule : rtsc_ctrl

/* File: hdl/rtsc_pkg.sv */
package rtsc_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  // Times in microseconds as printed
  localparam longint unsigned TURN_ON_DELAY_US = 2300000;
  localparam longint unsigned FAST_ON_DELAY_US = 4000;
  localparam longint unsigned RESET_HOLD_DELAY_US = 7500000;
  localparam longint unsigned FAST_RESET_DELAY_US = 1000;
  localparam longint unsigned RESET_OFF_PULSE_US = 400000;
  localparam longint unsigned WAKE_ON_DELAY_US = 4400;
  localparam longint unsigned SHUTDOWN_DELAY_US = 7300000;
  localparam longint unsigned FAST_SHUTDOWN_US = 600;
  localparam longint unsigned OFF_HOLD_MIN_US = 1000;
  localparam longint unsigned TRIM_WINDOW_US = 2000;
  // Microseconds to cycles: least times round up, longest round down
  function automatic longint unsigned rtsc_min_cyc(input longint unsigned us);
    return (us * CLK_HZ + 1000000 - 1) / 1000000;
  endfunction : rtsc_min_cyc
  function automatic longint unsigned rtsc_max_cyc(input longint unsigned us);
    longint unsigned c;
    c = us * CLK_HZ / 1000000;
    return (c == 0) ? 1 : c;
  endfunction : rtsc_max_cyc
  localparam int CNT_W = 32;
  localparam logic [CNT_W-1:0] FAST_ON_CYC = CNT_W'(rtsc_max_cyc(FAST_ON_DELAY_US));
  localparam logic [CNT_W-1:0] FAST_RESET_CYC = CNT_W'(rtsc_max_cyc(FAST_RESET_DELAY_US));
  localparam logic [CNT_W-1:0] WAKE_ON_CYC = CNT_W'(rtsc_min_cyc(WAKE_ON_DELAY_US));
  localparam logic [CNT_W-1:0] FAST_SHUTDOWN_CYC = CNT_W'(rtsc_max_cyc(FAST_SHUTDOWN_US));
  localparam logic [CNT_W-1:0] OFF_HOLD_CYC = CNT_W'(rtsc_min_cyc(OFF_HOLD_MIN_US));
  localparam logic [CNT_W-1:0] TRIM_WINDOW_CYC = CNT_W'(rtsc_min_cyc(TRIM_WINDOW_US));
  // Trim codes, multiplier in quarters
  typedef enum logic [2:0] {
    TRIM_GND, TRIM_3K9, TRIM_10K, TRIM_22K, TRIM_47K, TRIM_120K, TRIM_VBAT
  } rtsc_trim_t;
  localparam logic [3:0] QTR_ONE = 4'h4;
  // Synchronised input bundle
  typedef struct packed {
    logic key_n;
    logic wake;
    logic off;
    logic fast_n;
  } rtsc_in_t;
  localparam rtsc_in_t IN_POR = '{key_n: 1'b1, wake: 1'b0, off: 1'b0, fast_n: 1'b1};
endpackage : rtsc_pkg

/* File: hdl/rtsc_sync.sv */
`timescale 1ns/10ps
module rtsc_sync
  import rtsc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire rtsc_in_t raw_in,
  output rtsc_in_t sync_out,
  output rtsc_in_t prev_out
);
  rtsc_in_t stage1;
  rtsc_in_t stage2;
  rtsc_in_t stage3;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      stage1 <= IN_POR;
      stage2 <= IN_POR;
      stage3 <= IN_POR;
    end else begin
      stage1 <= raw_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end
  assign sync_out = stage2;
  assign prev_out = stage3;
endmodule : rtsc_sync

/* File: test/reset_timer_switch_control_bench.sv */
`timescale 1ns/10ps
module reset_timer_switch_control_bench;
  import rtsc_pkg::*;
  logic clk_sys_in;
  logic rst_in;
  logic power_key_n_in;
  logic wake_request_in;
  logic shutdown_request_in;
  logic fast_select_n_in;
  logic [2:0] delay_trim_pin_in;
  logic delay_trim_pin_enable_out;
  logic switch_on_out;
  int boot_count;
  int num_errors;
  int checked;
  int cycles = 0;

  rtsc_ctrl #(
    .TURN_ON_CYC(32'hc8),
    .RESET_HOLD_CYC(32'h190),
    .RESET_OFF_CYC(32'h64),
    .SHUTDOWN_CYC(32'h12c)
  ) DUT (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .power_key_n_in(power_key_n_in),
    .wake_request_in(wake_request_in),
    .shutdown_request_in(shutdown_request_in),
    .fast_select_n_in(fast_select_n_in),
    .delay_trim_pin_in(delay_trim_pin_in),
    .delay_trim_pin_enable_out(delay_trim_pin_enable_out),
    .switch_on_out(switch_on_out)
  );

  rtsc_pmic_model pmic (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .supply_in(switch_on_out),
    .boot_count_out(boot_count)
  );

  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  // Run is expected to take about 83000 cycles
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 95000) begin
      num_errors++;
      $display("CHECK FAILED run length expected below 95000 seen %0d", cycles);
      end_sim();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #2;
  endtask : tick

  // Output must keep one level for n cycles
  task automatic hold_sw(input string name, input logic val, input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      tick(1);
      if (switch_on_out !== val) bad++;
    end
    chk(name, 0, bad);
  endtask : hold_sw

  // Output must reach val no earlier than lo and no later than hi cycles
  task automatic wait_sw(input string name, input logic val, input int lo, input int hi);
    int n;
    n = lo;
    hold_sw({name, " early"}, ~val, lo);
    while (switch_on_out !== val && n < hi) begin
      tick(1);
      n++;
    end
    chk(name, val, switch_on_out);
  endtask : wait_sw

  task automatic sc_por;
    chk("switch after reset", 1, switch_on_out);
    chk("trim enable after reset", 0, delay_trim_pin_enable_out);
  endtask : sc_por

  task automatic sc_reset(input logic [2:0] code, input int lim, input logic off);
    delay_trim_pin_in = code;
    shutdown_request_in = off;
    power_key_n_in = 1'b0;
    tick(4);
    chk("trim enable after key fall", 1, delay_trim_pin_enable_out);
    wait_sw("reset off", 1'b0, lim - 20, lim + 20);
    wait_sw("reset on", 1'b1, 90, 110);
    power_key_n_in = 1'b1;
    shutdown_request_in = 1'b0;
    tick(20);
  endtask : sc_reset

  task automatic sc_release;
    delay_trim_pin_in = 3'h6;
    power_key_n_in = 1'b0;
    tick(200);
    power_key_n_in = 1'b1;
    hold_sw("early release keeps on", 1'b1, 600);
  endtask : sc_release

  task automatic sc_abort_and_power_on;
    shutdown_request_in = 1'b1;
    tick(25100);
    power_key_n_in = 1'b0;
    tick(20);
    power_key_n_in = 1'b1;
    hold_sw("abort keeps on", 1'b1, 600);
    shutdown_request_in = 1'b0;
    tick(10);
    shutdown_request_in = 1'b1;
    wait_sw("delayed off", 1'b0, 25280, 25340);
    shutdown_request_in = 1'b0;
    tick(10);
    wake_request_in = 1'b1;
    hold_sw("wake not early", 1'b0, 50);
    power_key_n_in = 1'b0;
    wait_sw("key turn on over wake", 1'b1, 190, 230);
    wake_request_in = 1'b0;
    hold_sw("no reset while held", 1'b1, 600);
    power_key_n_in = 1'b1;
    tick(20);
  endtask : sc_abort_and_power_on

  task automatic sc_fast_reset;
    fast_select_n_in = 1'b0;
    tick(5);
    power_key_n_in = 1'b0;
    wait_sw("fast reset off", 1'b0, 0, int'(FAST_RESET_CYC) + 10);
    wait_sw("fast reset on", 1'b1, 90, 110);
    power_key_n_in = 1'b1;
    fast_select_n_in = 1'b1;
    tick(20);
  endtask : sc_fast_reset

  initial begin
    num_errors = 0;
    checked = 0;
    rst_in = 1'b1;
    power_key_n_in = 1'b1;
    wake_request_in = 1'b0;
    shutdown_request_in = 1'b0;
    fast_select_n_in = 1'b1;
    delay_trim_pin_in = 3'h6;
    tick(12);
    rst_in = 1'b0;
    tick(5);
    sc_por();
    sc_reset(3'h6, 400, 1'b0);
    sc_reset(3'h0, 200, 1'b0);
    sc_reset(3'h1, 300, 1'b0);
    sc_reset(3'h2, 500, 1'b0);
    sc_reset(3'h3, 600, 1'b0);
    sc_reset(3'h4, 700, 1'b0);
    sc_reset(3'h7, 400, 1'b0);
    sc_reset(3'h5, 800, 1'b1);
    sc_release();
    sc_abort_and_power_on();
    sc_fast_reset();
    chk("pmic boot count", 10, boot_count);
    end_sim();
  end
endmodule : reset_timer_switch_control_bench

/* File: test/rtsc_pmic_model.sv */
`timescale 1ns/10ps
module rtsc_pmic_model (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic supply_in,
  output int boot_count_out
);
  logic last_supply;
  // Each return of supply starts a fresh power-on sequence
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      last_supply <= 1'b1;
      boot_count_out <= 0;
    end else begin
      last_supply <= supply_in;
      if (supply_in && !last_supply) begin
        boot_count_out <= boot_count_out + 1;
      end
    end
  end
endmodule : rtsc_pmic_model
